/* File: rtl/sfo_field_out.sv */
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module sfo_field_out
    import sfo_pkg::*;
#(
    parameter int unsigned CYC_PER_SEC = CYC_PER_SEC_DFLT,
    parameter int unsigned NAME_DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire sfo_pins_t pins_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    output logic safety_out,
    output logic warn_out,
    output logic ready_out,
    output logic vehicle_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (CYC_PER_SEC < 2) begin : g_bad_sec
        $error("sfo_field_out: CYC_PER_SEC must be at least 2");
    end
    if (NAME_DEPTH < 2 || NAME_DEPTH > 256) begin : g_bad_name
        $error("sfo_field_out: NAME_DEPTH out of range");
    end

    localparam int unsigned PW = $clog2(CYC_PER_SEC);
    localparam int unsigned NW = $clog2(NAME_DEPTH);
    localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_SEC - 1);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage one feeds only stage two
    sfo_pins_t sync1_q, pin_s, pin_p;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_q <= '0;
            pin_s <= '0;
            pin_p <= '0;
        end else begin
            sync1_q <= pins_in;
            pin_s <= sync1_q;
            pin_p <= pin_s;
        end
    end

    // One evaluation per rising scan strobe
    logic scan_ev;
    assign scan_ev = pin_s.scan & ~pin_p.scan;

    ////////////////////////////////////////////////////////////////////////
    // Register file state
    sfo_cfg_t cfg_q, cfg_d;
    logic [UNIT_ADDR_W-1:0] unit_q, unit_d;
    logic priv_q, priv_d;
    logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
    logic [NW-1:0] nptr_q, nptr_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [DATA_W-1:0] name_rdata;
    logic irq_q, irq_d;

    // Field evaluation and output state
    logic [4:0] cnt_q, cnt_d;
    logic infr_q, infr_d;
    sfo_state_t state_q, state_d;
    logic [PW-1:0] pre_q, pre_d;
    logic [7:0] sec_q, sec_d;
    logic safe_q, safe_d, warn_q, warn_d;
    logic ready_q, ready_d;

    // Decoded write request
    logic [1:0] w_mode, w_warn;
    logic [4:0] w_cnt;
    logic [UNIT_ADDR_W-1:0] w_addr;
    logic cfg_legal, addr_match, cfg_ok, unit_ok, name_we;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write qualification
    always_comb begin
        w_mode = wdata_in[CFG_MODE_LSB +: 2];
        w_warn = wdata_in[CFG_WARN_LSB +: 2];
        w_cnt = wdata_in[CFG_CNT_LSB +: 5];
        w_addr = wdata_in[CFG_ADDR_LSB +: UNIT_ADDR_W];
        cfg_legal = (w_mode != 2'b11) && (w_warn != 2'b11)
                  && (w_cnt >= SCAN_CNT_MIN)
                  && (w_cnt <= SCAN_CNT_MAX);
        // Universal carried address, or universal unit, always matches
        addr_match = (w_addr == UNIVERSAL_ADDR)
                   || (unit_q == UNIVERSAL_ADDR)
                   || (w_addr == unit_q);
        // Operator session can never change the configuration, unit address or labels
        cfg_ok = priv_q && cfg_legal && addr_match;
        unit_ok = priv_q && (wdata_in[UNIT_ADDR_W-1:0] <= ADDR_MAX);
        name_we = wr_in && priv_q && hit(addr_in, OFF_NAME_DATA);
    end

    ////////////////////////////////////////////////////////////////////////
    // Register next values
    always_comb begin
        logic cfg_wr, unit_wr;
        cfg_wr = wr_in && hit(addr_in, OFF_CFG);
        unit_wr = wr_in && hit(addr_in, OFF_UNIT_ADDR);
        cfg_d = cfg_q;
        unit_d = unit_q;
        priv_d = priv_q;
        irq_mask_d = irq_mask_q;
        nptr_d = nptr_q;
        if (cfg_wr && cfg_ok) begin
            cfg_d.mode = sfo_restart_t'(w_mode);
            cfg_d.startup_test = wdata_in[CFG_START_BIT];
            cfg_d.vehicle = wdata_in[CFG_APP_BIT];
            cfg_d.warn_sel = sfo_warn_sel_t'(w_warn);
            cfg_d.scan_cnt = w_cnt;
            cfg_d.delay_s = wdata_in[CFG_DLY_LSB +: 8];
        end
        if (unit_wr && unit_ok) begin
            unit_d = wdata_in[UNIT_ADDR_W-1:0];
        end
        // Key logs on, any other value logs off
        if (wr_in && hit(addr_in, OFF_SESSION)) begin
            priv_d = (wdata_in == LOGON_KEY);
        end
        if (wr_in && hit(addr_in, OFF_IRQ_MASK)) begin
            irq_mask_d = wdata_in[IRQ_W-1:0];
        end
        if (wr_in && hit(addr_in, OFF_NAME_PTR)) begin
            nptr_d = wdata_in[NW-1:0];
        end
        // Sticky events; a set in the clearing cycle wins
        irq_stat_d = irq_stat_q;
        if (wr_in && hit(addr_in, OFF_IRQ_STAT)) begin
            irq_stat_d = irq_stat_q & ~wdata_in[IRQ_W-1:0];
        end
        irq_stat_d[IRQ_INFR] = irq_stat_d[IRQ_INFR] | (infr_d & ~infr_q);
        irq_stat_d[IRQ_RESTORE] = irq_stat_d[IRQ_RESTORE] | (safe_d & ~safe_q);
        irq_stat_d[IRQ_REJECT] = irq_stat_d[IRQ_REJECT]
                               | ((cfg_wr && !cfg_ok) || (unit_wr && !unit_ok));
        irq_stat_d[IRQ_ACCEPT] = irq_stat_d[IRQ_ACCEPT]
                               | ((cfg_wr && cfg_ok) || (unit_wr && unit_ok));
        irq_d = |(irq_stat_d & irq_mask_d);
        // Reads are open to every session
        rdata_d = '0;
        if (rd_in) begin
            unique case (addr_in)
                OFF_CFG: rdata_d = {13'h0000, cfg_q.delay_s,
                                    cfg_q.scan_cnt, cfg_q.warn_sel,
                                    cfg_q.vehicle, cfg_q.startup_test,
                                    cfg_q.mode};
                OFF_UNIT_ADDR: rdata_d = {25'h0000000, unit_q};
                OFF_SESSION: rdata_d = {31'h00000000, priv_q};
                OFF_STATUS: rdata_d = {25'h0000000, state_q, priv_q, infr_q,
                                       warn_q, state_q != ST_START, safe_q};
                OFF_IRQ_STAT: rdata_d = {28'h0000000, irq_stat_q};
                OFF_IRQ_MASK: rdata_d = {28'h0000000, irq_mask_q};
                OFF_NAME_PTR: rdata_d = DATA_W'(nptr_q);
                OFF_NAME_DATA: rdata_d = name_rdata;
                default: rdata_d = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file flops
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_q <= CFG_RST;
            unit_q <= UNIVERSAL_ADDR;
            priv_q <= 1'b0;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            nptr_q <= '0;
            rdata_q <= '0;
            irq_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            unit_q <= unit_d;
            priv_q <= priv_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            nptr_q <= nptr_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    // Labels are stored and read back, never evaluated
    sfo_name_mem #(
        .WIDTH(DATA_W),
        .DEPTH(NAME_DEPTH)
    ) u_names (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .we_in(name_we),
        .waddr_in(nptr_q),
        .wdata_in(wdata_in),
        .raddr_in(nptr_q),
        .rdata_out(name_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Field evaluation, restart policy and warning next values
    always_comb begin
        cnt_d = cnt_q;
        infr_d = infr_q;
        if (scan_ev) begin
            if (pin_s.intrusion) begin
                if (cnt_q + 5'h01 >= cfg_q.scan_cnt) begin
                    infr_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 5'h01;
                end
            end else begin
                cnt_d = '0;
                infr_d = 1'b0;
            end
        end
        state_d = state_q;
        pre_d = '0;
        sec_d = '0;
        unique case (state_q)
            ST_START: begin
                // Held here until one interruption when testing is on
                if (!cfg_q.startup_test || infr_q) begin
                    state_d = ST_OFF;
                end
            end
            ST_OFF: begin
                if (!infr_q) begin
                    unique case (cfg_q.mode)
                        RST_INHIBIT: if (pin_s.restart_btn) begin
                            state_d = ST_ON;
                        end
                        RST_NODELAY: state_d = ST_ON;
                        default: state_d = ST_DELAY;
                    endcase
                end
            end
            ST_DELAY: begin
                pre_d = (pre_q == PRE_LAST) ? '0 : pre_q + PW'(1);
                sec_d = (pre_q == PRE_LAST) ? sec_q + 8'h01 : sec_q;
                if (infr_q) begin
                    state_d = ST_OFF;
                end else if (sec_q >= cfg_q.delay_s) begin
                    state_d = ST_ON;
                end
            end
            ST_ON: begin
                if (infr_q) begin
                    state_d = ST_OFF;
                end
            end
        endcase
        safe_d = (state_d == ST_ON);
        // Registered so the pin never glitches on a state decode
        ready_d = (state_d != ST_START);
        unique case (cfg_q.warn_sel)
            WARN_OBJECT: warn_d = pin_s.warn_obj;
            WARN_CONTAM: warn_d = pin_s.contam;
            default: warn_d = pin_s.warn_obj | pin_s.contam;
        endcase
    end

    // Evaluation flops
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
            infr_q <= 1'b0;
            state_q <= ST_START;
            pre_q <= '0;
            sec_q <= '0;
            safe_q <= 1'b0;
            warn_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            infr_q <= infr_d;
            state_q <= state_d;
            pre_q <= pre_d;
            sec_q <= sec_d;
            safe_q <= safe_d;
            warn_q <= warn_d;
            ready_q <= ready_d;
        end
    end

    assign rdata_out = rdata_q;
    assign safety_out = safe_q;
    assign warn_out = warn_q;
    assign ready_out = ready_q;
    assign vehicle_out = cfg_q.vehicle;
    assign irq_out = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_intruded_scan;
        scan_ev && pin_s.intrusion;
    endsequence
    sequence s_clear_scan;
        scan_ev && !pin_s.intrusion;
    endsequence

    property p_infr_count;
        $rose(infr_q) |-> $past(cnt_q) + 5'h01 >= cfg_q.scan_cnt
                          && $past(scan_ev) && $past(pin_s.intrusion);
    endproperty
    a_infr_count: assert property (p_infr_count)
        else $error("infringement without enough intruded scans");

    property p_clear_resets;
        s_clear_scan |=> cnt_q == 5'h00 && !infr_q;
    endproperty
    a_clear_resets: assert property (p_clear_resets)
        else $error("clear scan did not reset counter");

    property p_inhibit_button;
        $rose(safe_q) && cfg_q.mode == RST_INHIBIT && $past(state_q) == ST_OFF
            |-> $past(pin_s.restart_btn) && !$past(infr_q);
    endproperty
    a_inhibit_button: assert property (p_inhibit_button)
        else $error("restart without button in inhibit mode");

    property p_nodelay;
        state_q == ST_OFF && !infr_q && cfg_q.mode == RST_NODELAY
            |=> safe_q ##1 state_q == ST_ON;
    endproperty
    a_nodelay: assert property (p_nodelay)
        else $error("no-delay restart did not follow clear field");

    property p_delay_elapsed;
        $rose(safe_q) && $past(state_q) == ST_DELAY
            |-> $past(sec_q) >= cfg_q.delay_s && $past(pre_q) == '0;
    endproperty
    a_delay_elapsed: assert property (p_delay_elapsed)
        else $error("delayed restart came early");

    property p_startup_hold;
        state_q == ST_START && cfg_q.startup_test && !infr_q
            |=> !safe_q && !ready_out;
    endproperty
    a_startup_hold: assert property (p_startup_hold)
        else $error("ready before startup interruption");

    property p_warn_object;
        cfg_q.warn_sel == WARN_OBJECT && $stable(cfg_q)
            |=> warn_q == $past(pin_s.warn_obj);
    endproperty
    a_warn_object: assert property (p_warn_object)
        else $error("warning output ignores object-only selection");

    property p_addr_gate;
        wr_in && hit(addr_in, OFF_CFG) && unit_q != UNIVERSAL_ADDR
            && w_addr != UNIVERSAL_ADDR && w_addr != unit_q
            |=> cfg_q == $past(cfg_q) ##1 irq_stat_q[IRQ_REJECT];
    endproperty
    a_addr_gate: assert property (p_addr_gate)
        else $error("configuration accepted with wrong address");

    property p_priv_gate;
        wr_in && !priv_q && !hit(addr_in, OFF_SESSION)
            |=> cfg_q == $past(cfg_q) && unit_q == $past(unit_q);
    endproperty
    a_priv_gate: assert property (p_priv_gate)
        else $error("configuration changed without privilege");

endmodule // sfo_field_out

/* File: rtl/sfo_name_mem.sv */
`timescale 1ns/10ps
// Label storage; contents never reach the evaluation path
module sfo_name_mem
    import sfo_pkg::*;
#(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic we_in,
    input wire logic [$clog2(DEPTH)-1:0] waddr_in,
    input wire logic [WIDTH-1:0] wdata_in,
    input wire logic [$clog2(DEPTH)-1:0] raddr_in,
    output logic [WIDTH-1:0] rdata_out
);

    ////////////////////////////////////////////////////////////////////////
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
        $error("sfo_name_mem: DEPTH must be at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rdata_q;

    // Storage has no reset, so labels survive only as long as power
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_q[waddr_in] <= wdata_in;
        end
    end

    // Registered read port
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem_q[raddr_in];
        end
    end

    assign rdata_out = rdata_q;

endmodule // sfo_name_mem

/* File: rtl/sfo_pkg.sv */
package sfo_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register bus geometry and offsets
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_UNIT_ADDR = 8'h04;
    localparam logic [7:0] OFF_SESSION = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_NAME_PTR = 8'h18;
    localparam logic [7:0] OFF_NAME_DATA = 8'h1C;

    ////////////////////////////////////////////////////////////////////////
    // Configuration word field positions
    localparam int unsigned CFG_MODE_LSB = 0;
    localparam int unsigned CFG_START_BIT = 2;
    localparam int unsigned CFG_APP_BIT = 3;
    localparam int unsigned CFG_WARN_LSB = 4;
    localparam int unsigned CFG_CNT_LSB = 6;
    localparam int unsigned CFG_DLY_LSB = 11;
    localparam int unsigned CFG_ADDR_LSB = 24;
    localparam int unsigned UNIT_ADDR_W = 7;

    // Status word field positions
    localparam int unsigned ST_SAFE_BIT = 0;
    localparam int unsigned ST_READY_BIT = 1;
    localparam int unsigned ST_WARN_BIT = 2;
    localparam int unsigned ST_INFR_BIT = 3;
    localparam int unsigned ST_PRIV_BIT = 4;
    localparam int unsigned ST_FSM_LSB = 5;

    // Interrupt status bits
    localparam int unsigned IRQ_INFR = 0;
    localparam int unsigned IRQ_RESTORE = 1;
    localparam int unsigned IRQ_REJECT = 2;
    localparam int unsigned IRQ_ACCEPT = 3;
    localparam int unsigned IRQ_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // Limits, reset values and keys
    localparam logic [4:0] SCAN_CNT_MIN = 5'h02;
    localparam logic [4:0] SCAN_CNT_MAX = 5'h10;
    localparam logic [4:0] SCAN_CNT_RST = 5'h02;
    localparam logic [6:0] ADDR_MAX = 7'h63;
    localparam logic [6:0] UNIVERSAL_ADDR = 7'h00;
    localparam logic [7:0] DELAY_RST = 8'h00;
    // Startup test is on after reset; a cleared config would skip it
    localparam logic START_TEST_RST = 1'b1;
    // Logon key value is arbitrary
    localparam logic [31:0] LOGON_KEY = 32'h0000_5AF0;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned SECOND_S = 1;
    localparam int unsigned CYC_PER_SEC_DFLT = CLK_FREQ_HZ * SECOND_S;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        RST_INHIBIT = 2'b00,
        RST_NODELAY = 2'b01,
        RST_DELAYED = 2'b10
    } sfo_restart_t;

    typedef enum logic [1:0] {
        WARN_BOTH = 2'b00,
        WARN_OBJECT = 2'b01,
        WARN_CONTAM = 2'b10
    } sfo_warn_sel_t;

    typedef enum logic [1:0] {
        ST_START = 2'b00,
        ST_OFF = 2'b01,
        ST_DELAY = 2'b10,
        ST_ON = 2'b11
    } sfo_state_t;

    typedef struct packed {
        logic [7:0] delay_s;
        logic [4:0] scan_cnt;
        sfo_warn_sel_t warn_sel;
        logic vehicle;
        logic startup_test;
        sfo_restart_t mode;
    } sfo_cfg_t;

    typedef struct packed {
        logic scan;
        logic intrusion;
        logic warn_obj;
        logic contam;
        logic restart_btn;
    } sfo_pins_t;

    localparam sfo_cfg_t CFG_RST = '{DELAY_RST, SCAN_CNT_RST, WARN_BOTH,
                                     1'b0, START_TEST_RST, RST_INHIBIT};

endpackage

/* File: verification/safety_field_output_logic_tb.sv */
`timescale 1ns/10ps
module safety_field_output_logic_tb
    import sfo_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_n_in;
    logic [7:0] addr_in;
    logic [31:0] wdata_in;
    logic wr_in;
    logic rd_in;
    logic rd_q = 1'b0;
    logic [31:0] rdata_out;
    logic safety_out, warn_out, ready_out, vehicle_out, irq_out;
    sfo_pins_t pins;
    logic [31:0] exp_q[$];
    logic [31:0] c;
    logic [31:0] e_rd;
    logic [4:0] n;
    int n_fail = 0;
    int checks = 0;

    always #5 clk_in = ~clk_in;

    sfo_field_model u_field (.clk_in(clk_in), .pins_out(pins));

    sfo_field_out #(.CYC_PER_SEC(10)) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .pins_in(pins),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .safety_out(safety_out),
        .warn_out(warn_out), .ready_out(ready_out),
        .vehicle_out(vehicle_out), .irq_out(irq_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Config word; carried address is write-only so reads use ad = 0
    function automatic logic [31:0] cfgw(input logic [1:0] m,
        input logic [4:0] cnt, input logic [7:0] dly, input logic [6:0] ad,
        input logic veh, input logic [1:0] ws);
        return {1'b0, ad, 5'h00, dly, cnt, ws, veh, 1'b0, m};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        // Idle data is noise; nothing may latch it without a strobe
        wdata_in <= $urandom;
    endtask

    // Expected word is queued; the monitor below pairs it with the answer
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        exp_q.push_back(e);
        @(posedge clk_in);
        rd_in <= 1'b0;
        addr_in <= 8'($urandom);
    endtask

    // Output read by reference at the falling edge, not at the call,
    // so updates from the launching edge have landed
    task automatic chk(ref logic g, input logic e);
        @(negedge clk_in);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: output %b, expected %b", $time, g, e);
        end
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe
    always @(posedge clk_in) rd_q <= rd_in;
    always @(negedge clk_in) begin
        if (rd_q) begin
            e_rd = exp_q.pop_front();
            checks++;
            if (rdata_out !== e_rd) begin
                n_fail++;
                $display("wrong value at %0t: read %h, expected %h", $time,
                         rdata_out, e_rd);
            end
        end
    end

    task automatic print_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Whole run is under a thousand cycles; this cuts a hang
    initial begin
        wait_cyc(20000);
        n_fail++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hD35D));
        n = 5'($urandom % 15) + 5'h02;
        rst_n_in <= 1'b0;
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        addr_in <= 8'($urandom);
        wdata_in <= $urandom;
        wait_cyc(2);
        rst_n_in <= 1'b1;
        wait_cyc(2);
        // Startup test is on after reset: one debounced interruption
        chk(ready_out, 1'b0);
        u_field.do_scan(1'b1);
        chk(ready_out, 1'b0);
        u_field.do_scan(1'b1);
        chk(ready_out, 1'b1);
        chk(safety_out, 1'b0);
        u_field.do_scan(1'b0);
        rd(OFF_CFG, cfgw(2'h0, 5'h02, 8'h00, 7'h00, 1'b0, 2'h0) | 32'h4);
        wr(OFF_IRQ_MASK, 32'h4);
        wr(OFF_CFG, cfgw(2'h1, 5'h03, 8'h00, 7'h00, 1'b1, 2'h0));
        rd(OFF_CFG, cfgw(2'h0, 5'h02, 8'h00, 7'h00, 1'b0, 2'h0)
                    | 32'h4);
        rd(OFF_IRQ_STAT, 32'h5);
        chk(irq_out, 1'b1);
        wr(OFF_IRQ_STAT, 32'h4);
        wait_cyc(1);
        chk(irq_out, 1'b0);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0);
        wr(OFF_SESSION, LOGON_KEY);
        rd(OFF_SESSION, 32'h1);
        wr(OFF_UNIT_ADDR, 32'h5);
        wr(OFF_UNIT_ADDR, 32'h64);
        rd(OFF_UNIT_ADDR, 32'h5);
        wr(OFF_CFG, cfgw(2'h0, n, 8'h00, 7'h06, 1'b1, 2'h0));
        rd(OFF_CFG, cfgw(2'h0, 5'h02, 8'h00, 7'h00, 1'b0, 2'h0)
                    | 32'h4);
        wr(OFF_CFG, cfgw(2'h0, n, 8'h00, 7'h05, 1'b1, 2'h0));
        rd(OFF_CFG, cfgw(2'h0, n, 8'h00, 7'h00, 1'b1, 2'h0));
        chk(vehicle_out, 1'b1);
        wr(OFF_CFG, cfgw(2'h0, 5'h01, 8'h00, 7'h00, 1'b0, 2'h0));
        wr(OFF_CFG, cfgw(2'h0, 5'h11, 8'h00, 7'h00, 1'b0, 2'h0));
        rd(OFF_CFG, cfgw(2'h0, n, 8'h00, 7'h00, 1'b1, 2'h0));
        wr(OFF_CFG, cfgw(2'h0, n, 8'h00, 7'h00, 1'b0, 2'h0));
        rd(OFF_CFG, cfgw(2'h0, n, 8'h00, 7'h00, 1'b0, 2'h0));
        chk(vehicle_out, 1'b0);
        // Inhibit mode: button with clear field restores the output
        u_field.set_aux(1'b0, 1'b0, 1'b1);
        wait_cyc(6);
        chk(safety_out, 1'b1);
        u_field.set_aux(1'b0, 1'b0, 1'b0);
        // A clear scan one short of the count restarts the debounce
        repeat (n - 1) u_field.do_scan(1'b1);
        u_field.do_scan(1'b0);
        repeat (n - 1) u_field.do_scan(1'b1);
        chk(safety_out, 1'b1);
        u_field.do_scan(1'b1);
        chk(safety_out, 1'b0);
        u_field.do_scan(1'b0);
        wait_cyc(4);
        chk(safety_out, 1'b0);
        u_field.set_aux(1'b0, 1'b0, 1'b1);
        wait_cyc(6);
        chk(safety_out, 1'b1);
        u_field.set_aux(1'b0, 1'b0, 1'b0);
        // No-delay then delayed restart, both with a count of two
        wr(OFF_CFG, cfgw(2'h1, 5'h02, 8'h00, 7'h00, 1'b0, 2'h0));
        repeat (2) u_field.do_scan(1'b1);
        chk(safety_out, 1'b0);
        u_field.do_scan(1'b0);
        wait_cyc(3);
        chk(safety_out, 1'b1);
        wr(OFF_CFG, cfgw(2'h2, 5'h02, 8'h02, 7'h00, 1'b0, 2'h0));
        repeat (2) u_field.do_scan(1'b1);
        u_field.do_scan(1'b0);
        wait_cyc(10);
        chk(safety_out, 1'b0);
        wait_cyc(10);
        chk(safety_out, 1'b1);
        // Every warning selection against every pin combination
        for (int s = 0; s < 3; s++) begin
            wr(OFF_CFG, cfgw(2'h1, 5'h02, 8'h00, 7'h00, 1'b0, 2'(s)));
            for (int k = 0; k < 4; k++) begin
                u_field.set_aux(k[0], k[1], 1'b0);
                wait_cyc(5);
                chk(warn_out, (s == 0) ? (k[0] | k[1]) :
                    (s == 1) ? k[0] : k[1]);
            end
        end
        // Labels are stored and read back but leave the output alone
        c = $urandom;
        wr(OFF_NAME_PTR, 32'h3);
        wr(OFF_NAME_DATA, c);
        wait_cyc(2);
        rd(OFF_NAME_DATA, c);
        chk(safety_out, 1'b1);
        rd(OFF_NAME_PTR, 32'h3);
        // Status: on, ready, warning, privileged, state ON
        rd(OFF_STATUS, 32'h77);
        // Every event kind has fired by now; reject is unmasked
        rd(OFF_IRQ_STAT, 32'hF);
        chk(irq_out, 1'b1);
        wait_cyc(3);
        print_verdict();
    end
endmodule // safety_field_output_logic_tb

/* File: verification/sfo_field_model.sv */
`timescale 1ns/10ps
// Scan head, warning sensing and restart button as the block sees them
module sfo_field_model
    import sfo_pkg::*;
(
    input wire logic clk_in,
    output sfo_pins_t pins_out
);
    initial pins_out = '0;

    ////////////////////////////////////////////////////////////////////////
    // One scan; field state settles long before the strobe rises, since
    // the block samples it on the synced edge
    task automatic do_scan(input logic occ);
        @(posedge clk_in);
        pins_out.intrusion <= occ;
        repeat (4) @(posedge clk_in);
        pins_out.scan <= 1'b1;
        repeat (4) @(posedge clk_in);
        pins_out.scan <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask

    // Warning field, screen state and button are plain levels
    task automatic set_aux(input logic obj, input logic dirty, input logic btn);
        @(posedge clk_in);
        pins_out.warn_obj <= obj;
        pins_out.contam <= dirty;
        pins_out.restart_btn <= btn;
    endtask
endmodule // sfo_field_model
